//--- verilog/eeprom_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM target interface.
// Assumes: 200 MHz core clock; the serial clock pin is a second clock domain.
// Notes:   Functional notes for the target follow.
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  localparam int PROG_TIME_MS     = 5;
  // Longest time, so rounded down
  localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CNT_W       = 21;

  // ----------------------------------------------------------------
  // Array and addressing
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 11;
  localparam int MEM_DEPTH   = 2048;
  localparam int PAGE_BYTES  = 16;
  localparam int PAGE_W      = 4;
  // Device-type code; value is arbitrary
  localparam logic [3:0]        DEV_TYPE_CODE = 4'h5;
  localparam logic [ADDR_W-1:0] RST_ADDR      = 11'h000;

  // Synchroniser bit positions
  localparam int SYNC_SDA = 0;
  localparam int SYNC_SCL = 1;
  localparam int SYNC_TGL = 2;
  localparam int SYNC_WP  = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_WORD     = 4'h3,
    ST_WORD_ACK = 4'h4,
    ST_DATA     = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_TX       = 4'h7,
    ST_TX_ACK   = 4'h8
  } state_t;

  typedef struct packed {
    logic bit_v;
    logic tgl;
  } link_t;

  typedef struct packed {
    state_t                          st;
    logic [3:0]                      sync_a;
    logic [3:0]                      sync_b;
    logic [2:0]                      prev;
    logic [7:0]                      shreg;
    logic [7:0]                      txbyte;
    logic [3:0]                      bitcnt;
    logic [ADDR_W-1:0]               addr;
    logic [2:0]                      blk;
    logic                            rd;
    logic [PAGE_BYTES-1:0][7:0]      page_buf;
    logic [PAGE_BYTES-1:0]           page_vld;
    logic                            wr_pend;
    logic                            busy;
    logic [PROG_CNT_W-1:0]           prog_cnt;
    logic                            sda_oe;
    logic                            drv_lo;
  } core_t;

endpackage

//--- verilog/eeprom_target.sv
// Purpose: Serial EEPROM target: START/STOP, addressing, page write, reads.
// Assumes: scl_clk_in is the serial clock pin; sda pin split into in/out/oe.
// Notes:   Protocol runs on clk_in from synchronised pins; bits cross by toggle.
`timescale 1ns/1ps
module eeprom_target
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic scl_clk_in,
  input  wire logic sda_in,
  input  wire logic wp_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      prog_busy_out
);

  localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

  // ----------------------------------------------------------------
  // Link domain: sample data on each serial clock rise
  // ----------------------------------------------------------------
  link_t link_q;
  link_t link_d;

  always_comb begin
    link_d       = link_q;
    link_d.bit_v = sda_in;
    link_d.tgl   = ~link_q.tgl;
  end

  // Serial clock may stop between frames; nothing here needs a final edge
  always_ff @(posedge scl_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  core_t q;
  core_t d;

  logic [7:0] mem [MEM_DEPTH];

  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic       start_ev;
  logic       stop_ev;
  logic       bit_ev;
  logic       scl_fall;
  logic       rx_bit;
  logic       rx_rx_state;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic       prog_we;
  logic [3:0] prog_idx;

  assign scl_s    = q.sync_b[SYNC_SCL];
  assign sda_s    = q.sync_b[SYNC_SDA];
  assign wp_s     = q.sync_b[SYNC_WP];
  // Data edges while clock high are frame markers
  assign start_ev = scl_s && q.prev[SYNC_SCL] && q.prev[SYNC_SDA] && !sda_s;
  assign stop_ev  = scl_s && q.prev[SYNC_SCL] && !q.prev[SYNC_SDA] && sda_s;
  // Bit value is held stable by the link side until the next rise
  assign bit_ev   = q.sync_b[SYNC_TGL] ^ q.prev[SYNC_TGL];
  assign scl_fall = q.prev[SYNC_SCL] && !scl_s;
  assign rx_bit   = link_q.bit_v;
  assign rx_byte  = {q.shreg[6:0], rx_bit};
  assign rd_byte  = mem[q.addr];
  assign rx_rx_state = (q.st == ST_ADDR) || (q.st == ST_WORD) || (q.st == ST_DATA);
  assign byte_done   = bit_ev && rx_rx_state && (q.bitcnt == 4'h7);
  assign prog_idx = q.prog_cnt[PAGE_W-1:0];
  assign prog_we  = q.busy && (q.prog_cnt < PROG_CNT_W'(PAGE_BYTES)) && q.page_vld[prog_idx];

  always_comb begin
    logic do_load;
    do_load  = 1'b0;
    d        = q;
    d.sync_a = {wp_in, link_q.tgl, scl_clk_in, sda_in};
    d.sync_b = q.sync_a;
    d.prev   = q.sync_b[2:0];

    // Self-timed program cycle
    if (q.busy) begin
      d.prog_cnt = q.prog_cnt + PROG_CNT_W'(1);
      if (q.prog_cnt == PROG_LAST) begin
        d.busy     = 1'b0;
        d.page_vld = '0;
      end
    end

    if (start_ev) begin
      d.sda_oe = 1'b0;
      d.bitcnt = 4'h0;
      d.st     = q.busy ? ST_IDLE : ST_ADDR;
    end else if (stop_ev) begin
      d.st      = ST_IDLE;
      d.sda_oe  = 1'b0;
      d.wr_pend = 1'b0;
      if (q.wr_pend && !wp_s && !q.busy) begin
        d.busy     = 1'b1;
        d.prog_cnt = '0;
      end
    end else begin
      case (q.st)
        ST_ADDR, ST_WORD, ST_DATA: begin
          if (bit_ev) begin
            d.shreg  = rx_byte;
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (byte_done) begin
            d.bitcnt = 4'h0;
            if (q.st == ST_ADDR) begin
              if (rx_byte[7:4] == DEV_TYPE_CODE) begin
                d.blk = rx_byte[3:1];
                d.rd  = rx_byte[0];
                d.st  = ST_ADDR_ACK;
              end else begin
                d.st = ST_IDLE;
              end
            end else if (q.st == ST_WORD) begin
              d.addr     = {q.blk, rx_byte};
              d.page_vld = '0;
              d.st       = ST_WORD_ACK;
            end else begin
              // Later bytes overwrite the same slot after a wrap
              d.page_buf[q.addr[3:0]] = rx_byte;
              d.page_vld[q.addr[3:0]] = 1'b1;
              d.addr[3:0]             = q.addr[3:0] + 4'h1;
              d.wr_pend               = 1'b1;
              d.st                    = ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_WORD_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            if (!q.sda_oe) begin
              d.sda_oe = 1'b1;
            end else begin
              d.sda_oe = 1'b0;
              if (q.st == ST_ADDR_ACK && q.rd) begin
                do_load = 1'b1;
              end else if (q.st == ST_ADDR_ACK) begin
                d.st = ST_WORD;
              end else begin
                d.st = ST_DATA;
              end
            end
          end
        end
        ST_TX: begin
          if (bit_ev) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (q.bitcnt == 4'h8) begin
              d.sda_oe = 1'b0;
              d.bitcnt = 4'h0;
              d.st     = ST_TX_ACK;
            end else begin
              d.txbyte = {q.txbyte[6:0], 1'b0};
              d.sda_oe = ~q.txbyte[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (bit_ev) begin
            d.shreg[0] = rx_bit;
            d.bitcnt   = 4'h1;
          end
          if (scl_fall && q.bitcnt == 4'h1) begin
            if (!q.shreg[0]) begin
              do_load = 1'b1;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end

    if (do_load) begin
      d.txbyte = rd_byte;
      d.sda_oe = ~rd_byte[7];
      d.addr   = q.addr + ADDR_W'(1);
      d.bitcnt = 4'h0;
      d.st     = ST_TX;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q      <= '0;
      q.addr <= RST_ADDR;
    end else begin
      q <= d;
    end
  end

  // Bytes marked in page_vld land in the array in the first 16 cycles of a program cycle
  always_ff @(posedge clk_in) begin
    if (prog_we) begin
      mem[{q.addr[ADDR_W-1:PAGE_W], prog_idx}] <= q.page_buf[prog_idx];
    end
  end

  assign sda_out       = q.drv_lo;
  assign sda_oe_out    = q.sda_oe;
  assign prog_busy_out = q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence seq_addr_match;
    byte_done && q.st == ST_ADDR && rx_byte[7:4] == DEV_TYPE_CODE;
  endsequence

  sequence seq_data_in;
    byte_done && q.st == ST_DATA;
  endsequence

  sequence seq_ack_slot;
    scl_fall && !q.sda_oe &&
    (q.st == ST_ADDR_ACK || q.st == ST_WORD_ACK || q.st == ST_DATA_ACK);
  endsequence

  sequence seq_ack_end;
    scl_fall && q.sda_oe && !(q.st == ST_ADDR_ACK && q.rd) &&
    (q.st == ST_ADDR_ACK || q.st == ST_WORD_ACK || q.st == ST_DATA_ACK);
  endsequence

  sequence seq_read_load;
    scl_fall && q.sda_oe && q.st == ST_ADDR_ACK && q.rd;
  endsequence

  sequence seq_tx_done;
    scl_fall && q.st == ST_TX && q.bitcnt == 4'h8;
  endsequence

  sequence seq_tx_shift;
    scl_fall && q.st == ST_TX && q.bitcnt != 4'h8;
  endsequence

  sequence seq_host_ack;
    scl_fall && q.st == ST_TX_ACK && q.bitcnt == 4'h1 && !q.shreg[0];
  endsequence

  sequence seq_host_nack;
    scl_fall && q.st == ST_TX_ACK && q.bitcnt == 4'h1 && q.shreg[0];
  endsequence

  chk_busy_silent: assert property (q.busy |-> !q.sda_oe && q.st == ST_IDLE)
    else $error("bus active during program cycle");
  chk_prog_length: assert property ($fell(q.busy) |-> $past(q.prog_cnt) == PROG_LAST)
    else $error("program cycle length wrong");
  chk_prog_bound: assert property (q.busy |-> q.prog_cnt <= PROG_LAST)
    else $error("program counter overran");
  chk_wp_noprog: assert property (stop_ev && wp_s && !q.busy |=> !q.busy)
    else $error("protected write started programming");
  chk_prog_start: assert property (stop_ev && q.wr_pend && !wp_s && !q.busy |=> q.busy)
    else $error("program not started at stop");
  chk_addr_dir: assert property (seq_addr_match |=> q.rd == $past(rx_bit) ##0
                                 q.st == ST_ADDR_ACK)
    else $error("address byte not decoded");
  chk_addr_miss: assert property (byte_done && q.st == ST_ADDR &&
                                  rx_byte[7:4] != DEV_TYPE_CODE |=> q.st == ST_IDLE)
    else $error("foreign address not ignored");
  chk_page_wrap: assert property (seq_data_in |=>
                                  q.addr[3:0] == $past(q.addr[3:0]) + 4'h1 &&
                                  q.addr[10:4] == $past(q.addr[10:4]))
    else $error("page pointer wrong");
  chk_ack_drive: assert property (seq_ack_slot |=> q.sda_oe)
    else $error("byte not acknowledged");
  chk_stop_release: assert property (stop_ev |=> !q.sda_oe && q.st == ST_IDLE)
    else $error("stop did not release bus");
  chk_open_drain: assert property (!sda_out)
    else $error("data line driven high");
  chk_start_only: assert property (q.st == ST_IDLE && !start_ev |=> q.st == ST_IDLE)
    else $error("left idle without start");

  // ----------------------------------------------------------------
  // Byte framing and acknowledge
  // ----------------------------------------------------------------
  chk_rx_count: assert property (bit_ev && rx_rx_state && !byte_done
                                 && !start_ev && !stop_ev |=> q.bitcnt == $past(q.bitcnt) + 4'h1)
    else $error("bit count did not advance");

  chk_rx_quiet: assert property (rx_rx_state |-> !q.sda_oe)
    else $error("receiver drove data bits");

  // Read direction leaves the slot by loading data, checked below
  chk_ack_release: assert property (seq_ack_end |=> !q.sda_oe &&
                                    (q.st == ST_WORD || q.st == ST_DATA))
    else $error("acknowledge not released");

  chk_word_load: assert property (byte_done && q.st == ST_WORD && !start_ev && !stop_ev
                                  |=> q.st == ST_WORD_ACK && q.addr == {$past(q.blk), $past(rx_byte)})
    else $error("byte address not loaded");

  chk_page_store: assert property (seq_data_in |=> q.wr_pend &&
                                   q.page_buf[$past(q.addr[3:0])] == $past(rx_byte))
    else $error("data byte not buffered");

  chk_page_mark: assert property (seq_data_in |=> q.page_vld[$past(q.addr[3:0])])
    else $error("buffered byte not marked");

  // ----------------------------------------------------------------
  // Read transfer
  // ----------------------------------------------------------------
  chk_tx_first: assert property (seq_read_load |=> q.st == ST_TX &&
                                 q.sda_oe == !$past(rd_byte[7]))
    else $error("first read bit wrong");

  chk_tx_shift: assert property (seq_tx_shift |=>
                                 q.sda_oe == !$past(q.txbyte[6]))
    else $error("read bit wrong");

  chk_tx_release: assert property (seq_tx_done |=> !q.sda_oe && q.st == ST_TX_ACK)
    else $error("line not released for host acknowledge");

  chk_host_next: assert property (seq_host_ack |=> q.st == ST_TX &&
                                  q.addr == $past(q.addr) + ADDR_W'(1))
    else $error("next read byte not loaded");

  chk_nack_idle: assert property (seq_host_nack |=> q.st == ST_IDLE)
    else $error("read went on after no acknowledge");

  // ----------------------------------------------------------------
  // Program cycle
  // ----------------------------------------------------------------
  chk_prog_zero: assert property ($rose(q.busy) |-> q.prog_cnt == PROG_CNT_W'(0))
    else $error("program counter not cleared");

  chk_prog_step: assert property (q.busy && $past(q.busy) |->
                                  q.prog_cnt == $past(q.prog_cnt) + PROG_CNT_W'(1))
    else $error("program counter skipped");

  chk_prog_clear: assert property ($fell(q.busy) |-> q.page_vld == '0)
    else $error("page buffer not emptied");

  // Page base must not move while the array is written
  chk_busy_addr: assert property (q.busy |=> $stable(q.addr))
    else $error("address moved during program cycle");

  chk_busy_start: assert property (start_ev && q.busy |=> q.st == ST_IDLE && !q.sda_oe)
    else $error("start answered while programming");

  chk_busy_end: assert property ($fell(q.busy) |-> q.st == ST_IDLE)
    else $error("bus active at end of program cycle");

  chk_idle_quiet: assert property (q.st == ST_IDLE |-> !q.sda_oe)
    else $error("line pulled while idle");

  chk_stop_clear: assert property (stop_ev |=> !q.wr_pend)
    else $error("pending write survived stop");

  chk_wp_keep: assert property (stop_ev && wp_s |=> !q.busy || $past(q.busy))
    else $error("protected array programmed");

endmodule // eeprom_target

//--- sim/ctl_model.sv
// Purpose: Behavioural bus controller that drives the serial clock and data.
// Assumes: Data wire resolved in the bench with a pull-up.
// Notes:   Phases of 22 clk_in cycles; clock stands high between frames.
`timescale 1ns/1ps
module ctl_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  task automatic ph();
    repeat (22) @(negedge clk_in);
  endtask

  // Serves as repeated start too, entered with the clock low
  task automatic start();
    sda_low_out = 1'b0;
    ph();
    scl_out = 1'b1;
    ph();
    sda_low_out = 1'b1;
    ph();
    scl_out = 1'b0;
    ph();
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    ph();
    scl_out = 1'b1;
    ph();
    sda_low_out = 1'b0;
    ph();
  endtask

  // Data moves mid-low so the target never sees it change with clock high
  task automatic bit_x(input logic b, output logic r);
    sda_low_out = ~b;
    ph();
    scl_out = 1'b1;
    ph();
    r = sda_in;
    scl_out = 1'b0;
    ph();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic ack_m, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~ack_m, r);
  endtask
endmodule // ctl_model

//--- sim/tb_i2c_eeprom_target_write_path.sv
// Purpose: Self-checking bench for the serial EEPROM target.
// Assumes: Controller model paces the serial clock from clk_in.
// Notes:   Program cycle shortened so polling and run length stay small.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_i2c_eeprom_target_write_path import eeprom_pkg::*;;
  localparam int unsigned PROG = 2000;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        wp_in = 1'b0;
  logic        scl, sda_low, sda_out, sda_oe_out, prog_busy_out;
  wire         sda = ~((sda_oe_out & ~sda_out) | sda_low);
  logic [7:0]  exp_mem [MEM_DEPTH];
  int unsigned run = 0;
  int unsigned last_run = 0;
  int          err_total = 0;
  int          samples_checked = 0;

  always #2.5 clk_in = ~clk_in;

  eeprom_target #(.PROG_CYCLES(PROG)) i_eeprom_target (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .scl_clk_in(scl), .sda_in(sda),
    .wp_in(wp_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .prog_busy_out(prog_busy_out));
  ctl_model i_ctl_model (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));

  // Length of the last busy stretch, seen from outside
  always @(posedge clk_in) begin
    if (prog_busy_out === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        last_run <= run;
      end
      run <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Shared sequences
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic addr(input logic [10:0] a, input logic rw, input logic ack_e);
    logic ack;
    i_ctl_model.wbyte({DEV_TYPE_CODE, a[10:8], rw}, ack);
    `CHK(ack, ack_e)
  endtask

  task automatic wr(input logic [10:0] a, input int n, input logic [7:0] base);
    logic ack;
    i_ctl_model.start();
    addr(a, 1'b0, 1'b1);
    i_ctl_model.wbyte(a[7:0], ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_ctl_model.wbyte(base + 8'(i), ack);
      `CHK(ack, 1'b1)
      if (wp_in === 1'b0) begin
        exp_mem[{a[10:4], a[3:0] + 4'(i)}] = base + 8'(i);
      end
    end
    i_ctl_model.stop();
  endtask

  task automatic rd(input logic [10:0] a, input int n);
    logic ack;
    logic [7:0] d;
    i_ctl_model.start();
    addr(a, 1'b0, 1'b1);
    i_ctl_model.wbyte(a[7:0], ack);
    i_ctl_model.start();
    addr(a, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_ctl_model.rbyte(i < n - 1, d);
      `CHK(d, exp_mem[a + 11'(i)])
    end
    i_ctl_model.stop();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (prog_busy_out !== 1'b0 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    if (k == 3000) begin
      err_total++;
      summarize();
    end
    @(negedge clk_in);
    `CHK(last_run, PROG)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_code();
    logic ack;
    `CHK(sda_oe_out, 1'b0)
    i_ctl_model.start();
    i_ctl_model.wbyte({~DEV_TYPE_CODE, 4'h0}, ack);
    `CHK(ack, 1'b0)
    i_ctl_model.stop();
    `CHK(sda_out, 1'b0)
    $display("test code done");
  endtask

  task automatic t_byte();
    wr(11'h325, 1, 8'hA5);
    `CHK(prog_busy_out, 1'b1)
    i_ctl_model.start();
    addr(11'h325, 1'b0, 1'b0);
    i_ctl_model.stop();
    wait_idle();
    i_ctl_model.start();
    addr(11'h325, 1'b0, 1'b1);
    i_ctl_model.stop();
    rd(11'h325, 1);
    $display("test byte done");
  endtask

  task automatic t_page();
    logic [7:0] d;
    wr(11'h000, 1, 8'h3C);
    wait_idle();
    // More than a page: the last two land where the first two did, at 7F8 and 7F9
    wr(11'h7F8, 18, 8'h10);
    wait_idle();
    rd(11'h7F0, 16);
    i_ctl_model.start();
    addr(11'h000, 1'b1, 1'b1);
    i_ctl_model.rbyte(1'b0, d);
    `CHK(d, exp_mem[0])
    i_ctl_model.stop();
    rd(11'h7FF, 2);
    $display("test page done");
  endtask

  task automatic t_wp();
    wp_in = 1'b1;
    repeat (4) @(negedge clk_in);
    wr(11'h325, 1, 8'h77);
    repeat (8) @(negedge clk_in);
    `CHK(prog_busy_out, 1'b0)
    wp_in = 1'b0;
    rd(11'h325, 1);
    $display("test protect done");
  endtask

  initial begin
    repeat (4) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_code();
    t_byte();
    t_page();
    t_wp();
    summarize();
  end
endmodule // tb_i2c_eeprom_target_write_path
